// ### src/rsx_pkg.sv
// Package for the rotate, subtract, set and skip execution block.
// Assumes a single 50 MHz core clock and a synchronous active-high reset.
//
// Notes on behaviour
// (RULE_01) Rotate memory left, bit7 to bit0, flags kept
// (RULE_02) Rotate left into work register, memory kept
// (RULE_03) Nine-bit left rotate via carry to memory
// (RULE_04) Nine-bit left rotate via carry to work
// (RULE_05) Rotate memory right, bit0 to bit7, flags kept
// (RULE_06) Rotate right into work register, memory kept
// (RULE_07) Nine-bit right rotate via carry to memory
// (RULE_08) Nine-bit right rotate via carry to work
// (RULE_09) Work plus inverted byte plus carry to work
// (RULE_10) Same borrow subtract result written to memory
// (RULE_11) Decrement memory, skip on zero, two cycles
// (RULE_12) Decrement into work register, skip on zero
// (RULE_13) Increment memory, skip on zero, two cycles
// (RULE_14) Increment into work register, skip on zero
// (RULE_15) Set byte writes all ones, flags kept
// (RULE_16) Set bit forces one selected bit only
// (RULE_17) Skip with dummy cycle when selected bit one
// (RULE_18) Subtract byte: work plus inverted plus one
// (RULE_19) Immediate subtract from work register
// (RULE_20) Carry means no borrow; zero, half, signed flags
package rsx_pkg;

	// Wishbone register offsets (byte addresses)
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_OPND   = 4'h4;
	localparam logic [3:0] OFS_WORK   = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;

	// Control register fields
	localparam int CTRL_OP_LSB  = 0;
	localparam int CTRL_BIT_LSB = 8;
	localparam int CTRL_GO_BIT  = 31;

	// Status register fields
	localparam int ST_CY_BIT   = 0;
	localparam int ST_HC_BIT   = 1;
	localparam int ST_ZF_BIT   = 2;
	localparam int ST_WRAP_BIT = 3;
	localparam int ST_SKIP_BIT = 4;
	localparam int ST_BUSY_BIT = 5;

	// Reset values and the set-byte pattern
	localparam logic [7:0] WORK_RST  = 8'h00;
	localparam logic [7:0] OPND_RST  = 8'h00;
	localparam logic [7:0] ALL_ONES  = 8'hFF;

	// Cycle figures
	localparam int CYC_NORMAL = 1;
	localparam int CYC_SKIP   = 2;

	// Operation codes
	typedef enum logic [4:0] {
		OP_NONE                 = 5'h00,
		OP_ROTATE_LEFT_MEM      = 5'h01,
		OP_ROTATE_LEFT_WORK     = 5'h02,
		OP_ROTATE_LEFT_CY_MEM   = 5'h03,
		OP_ROTATE_LEFT_CY_WORK  = 5'h04,
		OP_ROTATE_RIGHT_MEM     = 5'h05,
		OP_ROTATE_RIGHT_WORK    = 5'h06,
		OP_ROTATE_RIGHT_CY_MEM  = 5'h07,
		OP_ROTATE_RIGHT_CY_WORK = 5'h08,
		OP_BORROW_WORK          = 5'h09,
		OP_BORROW_MEM           = 5'h0A,
		OP_DSZ_MEM              = 5'h0B,
		OP_DSZ_WORK             = 5'h0C,
		OP_ISZ_MEM              = 5'h0D,
		OP_ISZ_WORK             = 5'h0E,
		OP_SET_BYTE             = 5'h0F,
		OP_SET_BIT              = 5'h10,
		OP_SKIP_NZ              = 5'h11,
		OP_SUB_WORK             = 5'h12,
		OP_SUB_MEM              = 5'h13,
		OP_SUB_IMM              = 5'h14
	} op_type;

	// Flags carried together
	typedef struct packed {
		logic wrap;
		logic zf;
		logic hc;
		logic cy;
	} flags_type;

	// Execution result carried together
	typedef struct packed {
		logic [7:0] value;
		logic       to_mem;
		logic       to_work;
		logic       skip;
		flags_type  flags;
		logic [3:0] flag_we;
	} result_type;

	// Execution state
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_DUMMY = 2'b10
	} state_type;

endpackage

// ### src/rsx_exec.sv
// Execution unit for rotates, subtracts, set and skip operations.
// Software drives it over classic Wishbone; the operand byte stands
// in for the addressed data memory location.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module rsx_exec
	import rsx_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Execution visibility
	output logic             busy,
	output logic             skip_pulse
);

	////////////////////////////////////////////////////////////////////
	// Declarations
	op_type     op_r;
	logic [2:0] bit_sel_r;
	logic [7:0] work_r;
	logic [7:0] opnd_r;
	flags_type  flags_r;
	logic       skip_r;
	state_type  state_r;
	result_type res;
	logic       wb_req;
	logic       wr_ctrl;
	logic       go;

	// Nine-bit add of the inverted operand, shared by every subtract form;
	// returns {signed wrap, half carry, carry, sum}
	function automatic logic [10:0] sub_core(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [8:0] full;
		logic       wrap;
		lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		wrap = (a[7] == b[7]) && (full[7] != a[7]);
		return {wrap, lo[4], full[8], full[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Wishbone decode
	assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == OFS_CTRL) && wb_sel_i[3];
	assign go      = wr_ctrl && wb_dat_i[CTRL_GO_BIT] && (state_r == ST_IDLE);

	// One-cycle ack, dropped the cycle after
	always_ff @(posedge clk)
	begin
		if (srst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	// Read data, registered
	always_ff @(posedge clk)
	begin
		if (srst)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_req && !wb_we_i)
		begin
			if (wb_adr_i == OFS_CTRL)
				wb_dat_o <= {24'h000000, 5'h00, bit_sel_r} << CTRL_BIT_LSB
					| {27'h0000000, op_r};
			else if (wb_adr_i == OFS_OPND)
				wb_dat_o <= {24'h000000, opnd_r};
			else if (wb_adr_i == OFS_WORK)
				wb_dat_o <= {24'h000000, work_r};
			else if (wb_adr_i == OFS_STATUS)
				wb_dat_o <= {26'h0000000, (state_r != ST_IDLE), skip_r,
					flags_r.wrap, flags_r.zf, flags_r.hc, flags_r.cy};
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Combinational datapath
	always_comb
	begin
		logic [10:0] sr;
		logic [7:0]  b;
		logic        cin;
		sr  = 11'h000;
		b   = 8'h00;
		cin = 1'b0;
		res = '0;
		res.flags = flags_r;
		case (op_r)
			OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_WORK:
			begin
				res.value   = {opnd_r[6:0], opnd_r[7]}; // see RULE_01 see RULE_02
				res.to_mem  = (op_r == OP_ROTATE_LEFT_MEM);
				res.to_work = (op_r == OP_ROTATE_LEFT_WORK);
			end
			OP_ROTATE_LEFT_CY_MEM, OP_ROTATE_LEFT_CY_WORK:
			begin
				res.value    = {opnd_r[6:0], flags_r.cy}; // see RULE_03 see RULE_04
				res.flags.cy = opnd_r[7];
				res.flag_we  = 4'h1;
				res.to_mem   = (op_r == OP_ROTATE_LEFT_CY_MEM);
				res.to_work  = (op_r == OP_ROTATE_LEFT_CY_WORK);
			end
			OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_WORK:
			begin
				res.value   = {opnd_r[0], opnd_r[7:1]}; // see RULE_05 see RULE_06
				res.to_mem  = (op_r == OP_ROTATE_RIGHT_MEM);
				res.to_work = (op_r == OP_ROTATE_RIGHT_WORK);
			end
			OP_ROTATE_RIGHT_CY_MEM, OP_ROTATE_RIGHT_CY_WORK:
			begin
				res.value    = {flags_r.cy, opnd_r[7:1]}; // see RULE_07 see RULE_08
				res.flags.cy = opnd_r[0];
				res.flag_we  = 4'h1;
				res.to_mem   = (op_r == OP_ROTATE_RIGHT_CY_MEM);
				res.to_work  = (op_r == OP_ROTATE_RIGHT_CY_WORK);
			end
			OP_BORROW_WORK, OP_BORROW_MEM, OP_SUB_WORK, OP_SUB_MEM, OP_SUB_IMM:
			begin
				// Subtract as add of inverse; carry set means no borrow
				b   = ~opnd_r; // see RULE_19
				cin = 1'b1; // see RULE_18
				if (op_r == OP_BORROW_WORK || op_r == OP_BORROW_MEM)
					cin = flags_r.cy; // see RULE_09
				sr  = sub_core(work_r, b, cin);
				res.value      = sr[7:0];
				res.flags.cy   = sr[8]; // see RULE_20
				res.flags.hc   = sr[9];
				res.flags.zf   = (sr[7:0] == 8'h00);
				res.flags.wrap = sr[10];
				res.flag_we    = 4'hF;
				res.to_mem     = (op_r == OP_BORROW_MEM || op_r == OP_SUB_MEM); // see RULE_10
				res.to_work  = !res.to_mem;
			end
			OP_DSZ_MEM, OP_DSZ_WORK:
			begin
				res.value   = opnd_r - 8'h01; // see RULE_11 see RULE_12
				res.skip    = (res.value == 8'h00);
				res.to_mem  = (op_r == OP_DSZ_MEM);
				res.to_work = (op_r == OP_DSZ_WORK);
			end
			OP_ISZ_MEM, OP_ISZ_WORK:
			begin
				res.value   = opnd_r + 8'h01; // see RULE_13 see RULE_14
				res.skip    = (res.value == 8'h00);
				res.to_mem  = (op_r == OP_ISZ_MEM);
				res.to_work = (op_r == OP_ISZ_WORK);
			end
			OP_SET_BYTE:
			begin
				res.value  = ALL_ONES; // see RULE_15
				res.to_mem = 1'b1;
			end
			OP_SET_BIT:
			begin
				res.value  = opnd_r | (8'h01 << bit_sel_r); // see RULE_16
				res.to_mem = 1'b1;
			end
			OP_SKIP_NZ:
			begin
				res.value = opnd_r;
				res.skip  = opnd_r[bit_sel_r]; // see RULE_17
			end
			default:
			begin
				res.value = opnd_r;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Control register: opcode and bit select
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			op_r      <= OP_NONE;
			bit_sel_r <= 3'h0;
		end
		else if (wr_ctrl && state_r == ST_IDLE)
		begin
			op_r      <= op_type'(wb_dat_i[CTRL_OP_LSB +: 5]);
			bit_sel_r <= wb_dat_i[CTRL_BIT_LSB +: 3];
		end
	end

	// Execution sequencer: one cycle, plus dummy cycle on skip
	always_ff @(posedge clk)
	begin
		if (srst)
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:  if (go) state_r <= ST_EXEC;
				ST_EXEC:  state_r <= res.skip ? ST_DUMMY : ST_IDLE; // see RULE_11 see RULE_17
				ST_DUMMY: state_r <= ST_IDLE;
				default:  state_r <= ST_IDLE;
			endcase
		end
	end

	// Operand byte: software write, or result written back
	always_ff @(posedge clk)
	begin
		if (srst)
			opnd_r <= OPND_RST;
		else if (state_r == ST_EXEC && res.to_mem)
			opnd_r <= res.value;
		else if (state_r == ST_IDLE && wb_req && wb_we_i && wb_adr_i == OFS_OPND && wb_sel_i[0])
			opnd_r <= wb_dat_i[7:0];
	end

	// Work register
	always_ff @(posedge clk)
	begin
		if (srst)
			work_r <= WORK_RST;
		else if (state_r == ST_EXEC && res.to_work)
			work_r <= res.value;
		else if (state_r == ST_IDLE && wb_req && wb_we_i && wb_adr_i == OFS_WORK && wb_sel_i[0])
			work_r <= wb_dat_i[7:0];
	end

	// Flags: only those the operation affects
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			flags_r <= '0;
			skip_r  <= 1'b0;
		end
		else if (state_r == ST_EXEC)
		begin
			// Only the flags that the operation owns are taken from the result
			flags_r <= flags_type'((res.flags & res.flag_we) | (flags_r & ~res.flag_we));
			skip_r  <= res.skip;
		end
		else if (state_r == ST_IDLE && wb_req && wb_we_i && wb_adr_i == OFS_STATUS && wb_sel_i[0])
			flags_r <= flags_type'({wb_dat_i[ST_WRAP_BIT], wb_dat_i[ST_ZF_BIT],
				wb_dat_i[ST_HC_BIT], wb_dat_i[ST_CY_BIT]});
	end

	assign busy       = (state_r != ST_IDLE);
	assign skip_pulse = (state_r == ST_DUMMY);

	////////////////////////////////////////////////////////////////////
	// Assertions
	property p_rotl_mem;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_ROTATE_LEFT_MEM) |=>
			(opnd_r == {$past(opnd_r[6:0]), $past(opnd_r[7])}) && $stable(flags_r);
	endproperty
	a_rotl_mem: assert property (p_rotl_mem) else $error("rotate left memory wrong"); // see RULE_01

	property p_rotl_cy_work;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_ROTATE_LEFT_CY_WORK) |=>
			work_r == {$past(opnd_r[6:0]), $past(flags_r.cy)} && flags_r.cy == $past(opnd_r[7])
			&& $stable(opnd_r);
	endproperty
	a_rotl_cy_work: assert property (p_rotl_cy_work) else $error("rotate via carry wrong"); // see RULE_04

	property p_rotr_cy_mem;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_ROTATE_RIGHT_CY_MEM) |=>
			opnd_r == {$past(flags_r.cy), $past(opnd_r[7:1])} && flags_r.cy == $past(opnd_r[0]);
	endproperty
	a_rotr_cy_mem: assert property (p_rotr_cy_mem) else $error("rotate right carry wrong"); // see RULE_07

	property p_rotr_work;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_ROTATE_RIGHT_WORK) |=>
			work_r == {$past(opnd_r[0]), $past(opnd_r[7:1])} && $stable(opnd_r);
	endproperty
	a_rotr_work: assert property (p_rotr_work) else $error("rotate right work wrong"); // see RULE_06

	property p_sub_work;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_SUB_WORK) |=>
			work_r == 8'($past(work_r) - $past(opnd_r))
			&& flags_r.cy == ($past(work_r) >= $past(opnd_r));
	endproperty
	a_sub_work: assert property (p_sub_work) else $error("subtract wrong"); // see RULE_18

	property p_borrow_zero;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_BORROW_WORK) |=> flags_r.zf == (work_r == 8'h00);
	endproperty
	a_borrow_zero: assert property (p_borrow_zero) else $error("zero flag wrong"); // see RULE_20

	property p_skip_two;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_DSZ_MEM && opnd_r == 8'h01) |=>
			skip_pulse ##1 (state_r == ST_IDLE);
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("skip timing wrong"); // see RULE_11

	property p_noskip_one;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_SKIP_NZ && !opnd_r[bit_sel_r]) |=> state_r == ST_IDLE;
	endproperty
	a_noskip_one: assert property (p_noskip_one) else $error("no-skip timing wrong"); // see RULE_17

	property p_set_byte;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_SET_BYTE) |=> opnd_r == ALL_ONES && $stable(flags_r);
	endproperty
	a_set_byte: assert property (p_set_byte) else $error("set byte wrong"); // see RULE_15

	property p_inc_skip;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_ISZ_MEM) |=>
			opnd_r == 8'($past(opnd_r) + 8'h01) && skip_r == (opnd_r == 8'h00) && $stable(flags_r);
	endproperty
	a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong"); // see RULE_13

	property p_set_bit;
		@(posedge clk) disable iff (srst)
		(state_r == ST_EXEC && op_r == OP_SET_BIT) |=>
			opnd_r[bit_sel_r] && ($countones(opnd_r ^ $past(opnd_r)) <= 1) && $stable(flags_r);
	endproperty
	a_set_bit: assert property (p_set_bit) else $error("set bit wrong"); // see RULE_16

	c_skip:  cover property (@(posedge clk) disable iff (srst) skip_pulse);
	c_borrow: cover property (@(posedge clk) disable iff (srst) state_r == ST_EXEC && op_r == OP_BORROW_MEM);
	c_bit:   cover property (@(posedge clk) disable iff (srst) state_r == ST_EXEC && op_r == OP_SKIP_NZ && res.skip);
	c_isz:   cover property (@(posedge clk) disable iff (srst) state_r == ST_EXEC && op_r == OP_ISZ_WORK && res.skip);

endmodule

// ### testbench/test_mcu_rotate_sub_skip_exec.sv
// Self-checking bench for the rotate, subtract, set and skip unit.
// Assumes rsx_exec behind classic Wishbone, one 50 MHz clock, srst high.
`timescale 1ns/100ps
module test_mcu_rotate_sub_skip_exec;
	import rsx_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Design hookup
	logic        clk;
	logic        srst;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [3:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        busy;
	logic        skip_pulse;
	int          num_errors;
	int          checked;
	int          bcnt;
	int          pcnt;
	logic [7:0]  em;
	logic [7:0]  ea;
	logic [3:0]  ef;
	logic        esk;
	logic [31:0] rm;
	logic [31:0] ra;
	logic [31:0] rs;

	rsx_exec dut_u (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy), .skip_pulse(skip_pulse));

	// Compare, count and report a mismatch at once
	`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

	// Clock at 20 ns
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Count busy and skip cycles of the running operation
	always @(posedge clk)
	begin
		if (busy === 1'b1) bcnt++;
		if (skip_pulse === 1'b1) pcnt++;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus and operation helpers
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One classic cycle; request held until ack is sampled
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 20)
		begin
			num_errors++;
			$display("CHECK FAILED ack wait expected 1 seen 0");
			end_of_test();
		end
	endtask

	// Expected outcome worked out from the instruction semantics
	function automatic void calc(int op, logic [2:0] bs, logic [7:0] m, a, logic [3:0] fl);
		logic [8:0] s;
		logic       h;
		logic       c;
		c = fl[0];
		em = m;
		ea = a;
		ef = fl;
		esk = 1'b0;
		s = {1'b0, a} + {1'b0, ~m} + ((op == 9 || op == 10) ? {8'h00, c} : 9'h001);
		h = ({1'b0, a[3:0]} + {1'b0, ~m[3:0]} + ((op == 9 || op == 10) ? {4'h0, c} : 5'h01)) > 5'h0F;
		case (op)
			1: em = {m[6:0], m[7]};
			2: ea = {m[6:0], m[7]};
			3: {ef[0], em} = {m, c};
			4: {ef[0], ea} = {m, c};
			5: em = {m[0], m[7:1]};
			6: ea = {m[0], m[7:1]};
			7: {em, ef[0]} = {c, m};
			8: {ea, ef[0]} = {c, m};
			9, 18, 20: ea = s[7:0];
			10, 19: em = s[7:0];
			11: em = m - 8'h01;
			12: ea = m - 8'h01;
			13: em = m + 8'h01;
			14: ea = m + 8'h01;
			15: em = 8'hFF;
			16: em[bs] = 1'b1;
			17: esk = m[bs];
			default: ;
		endcase
		if (op == 11 || op == 13) esk = (em == 8'h00);
		if (op == 12 || op == 14) esk = (ea == 8'h00);
		if (op == 9 || op == 10 || op >= 18)
			ef = {(a[7] != m[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h, s[8]};
	endfunction

	// Load operands, start, wait for idle, read back and judge
	task automatic run(int op, logic [2:0] bs, logic [7:0] m, a, logic [3:0] fl);
		logic [31:0] q;
		int n;
		calc(op, bs, m, a, fl);
		wb(1'b1, 4'h4, {24'h000000, m}, q);
		wb(1'b1, 4'h8, {24'h000000, a}, q);
		wb(1'b1, 4'hC, {28'h0000000, fl}, q);
		bcnt = 0;
		pcnt = 0;
		wb(1'b1, 4'h0, {1'b1, 20'h00000, bs, 3'h0, 5'(op)}, q);
		n = 0;
		do
		begin
			wb(1'b0, 4'hC, 32'h00000000, rs);
			n++;
		end while (rs[5] !== 1'b0 && n < 10);
		if (rs[5] !== 1'b0)
		begin
			num_errors++;
			$display("CHECK FAILED busy wait expected 0 seen 1");
			end_of_test();
		end
		wb(1'b0, 4'h4, 32'h00000000, rm);
		wb(1'b0, 4'h8, 32'h00000000, ra);
		`CHK("memory byte", em, rm[7:0])
		`CHK("work register", ea, ra[7:0])
		`CHK("status", {1'b0, esk, ef}, rs[5:0])
		`CHK("busy cycles", (esk ? CYC_SKIP : CYC_NORMAL), bcnt)
		`CHK("skip pulses", {31'h0, esk}, pcnt)
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		logic [31:0] q;
		logic [3:0]  al[5];
		al = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
		`CHK("busy after reset", 1'b0, busy)
		`CHK("skip after reset", 1'b0, skip_pulse)
		wb(1'b1, 4'h6, 32'h000000FF, q);
		foreach (al[i])
		begin
			wb(1'b0, al[i], 32'h00000000, q);
			`CHK("reset value", 32'h00000000, q)
		end
		$display("reset test done");
	endtask

	task automatic t_rotate();
		for (int op = 1; op <= 8; op++)
			for (int k = 0; k < 4; k++)
				run(op, 3'h0, k[1] ? 8'h4E : 8'h81, 8'h3C, {3'b101, k[0]});
		$display("rotate test done");
	endtask

	task automatic t_subtract();
		int ops[5] = '{9, 10, 18, 19, 20};
		logic [7:0] ta[5] = '{8'h00, 8'h80, 8'h10, 8'h35, 8'h7F};
		logic [7:0] tm[5] = '{8'h01, 8'h01, 8'h10, 8'h0F, 8'hFF};
		foreach (ops[i])
			foreach (ta[j])
				run(ops[i], 3'h0, tm[j], ta[j], {3'b000, j[0]});
		$display("subtract test done");
	endtask

	task automatic t_skip();
		logic [7:0] tm[4] = '{8'h01, 8'h02, 8'hFF, 8'h00};
		for (int op = 11; op <= 14; op++)
			foreach (tm[j])
				run(op, 3'h0, tm[j], 8'h55, 4'hA);
		$display("skip test done");
	endtask

	task automatic t_set();
		run(15, 3'h0, 8'h5A, 8'h11, 4'h5);
		for (int b = 0; b < 8; b++)
		begin
			run(16, 3'(b), 8'h00, 8'h22, 4'hA);
			run(17, 3'(b), 8'hA5, 8'h33, 4'h5);
		end
		$display("set and bit skip test done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		num_errors = 0;
		checked = 0;
		bcnt = 0;
		pcnt = 0;
		srst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_sel = 4'hF;
		wb_dat = 32'h00000000;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_rotate();
		t_subtract();
		t_skip();
		t_set();
		// Reset again mid-run; every register must fall back to its reset value
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		end_of_test();
	end
endmodule
